/* File: hw/ddx_pkg.sv */
package ddx_pkg;
  // Instruction codes on the command port
  localparam logic [2:0] OP_DEC   = 3'h1;
  localparam logic [2:0] OP_DIV   = 3'h2;
  localparam logic [2:0] OP_FUZZY = 3'h3;
  localparam logic [2:0] OP_HALT  = 3'h4;
  localparam logic [2:0] OP_OUT   = 3'h5;
  localparam logic [2:0] OP_FZI   = 3'h6;
  // Register byte addresses
  localparam logic [31:0] A_CTRL   = 32'h0000_0000;
  localparam logic [31:0] A_FLAGS  = 32'h0000_0004;
  localparam logic [31:0] A_STAT   = 32'h0000_0008;
  localparam logic [31:0] A_MASK   = 32'h0000_000C;
  localparam logic [31:0] A_RAM    = 32'h0000_0100;
  localparam logic [31:0] A_RAM_HI = 32'h0000_04FF;
  // Flag bit positions
  localparam int F_NULL = 0;
  localparam int F_OVF  = 1;
  localparam int F_BRW  = 2;
  // Event bit positions
  localparam int E_DONE  = 0;
  localparam int E_DOVF  = 1;
  localparam int E_HALT  = 2;
  localparam int E_WAKE  = 3;
  localparam int E_ILL   = 4;
  localparam int EV_W    = 5;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam logic [2:0] FLAGS_RST = 3'h0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_FUZZ = 2'b11,
    ST_HALT = 2'b10
  } ddx_st_e;
endpackage

/* File: hw/ddx_core.sv */
`timescale 1ns/10ps
`default_nettype none
module ddx_core #(
  parameter int RAM_DEPTH = 256
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Instruction stream
  input  wire logic        instr_valid,
  input  wire logic [2:0]  instr_op,
  input  wire logic [7:0]  instr_dst,
  input  wire logic [7:0]  instr_src,
  output logic             instr_ready,
  // Wake-up pin
  input  wire logic        ext_irq,
  // Status outputs
  output logic             clk_run,
  output logic             halt_mode,
  output logic             fuzzy_active,
  output logic             fuzzy_start,
  output logic             irq
);

  // All block state in one word
  typedef struct packed {
    logic [RAM_DEPTH-1:0][7:0] ram;
    logic [2:0]             flags;
    logic [ddx_pkg::EV_W-1:0] stat;
    logic [ddx_pkg::EV_W-1:0] mask;
    ddx_pkg::ddx_st_e       st;
    logic [2:0]             op;
    logic [7:0]             dst;
    logic [7:0]             src;
    logic                   dp_act;
    logic                   dp_wr;
    logic [7:0]             dp_idx;
    logic [1:0]             dp_reg;
    logic                   dp_ram;
    logic [31:0]            rdata;
    logic                   irq_s1;
    logic                   irq_s2;
    logic                   fstart;
    logic                   irq;
    logic                   rdy;
    logic                   run;
    logic                   halt;
    logic                   fact;
    logic                   hrdyo;
    logic                   hrsp;
  } ddx_s;

  ddx_s r_ff;
  ddx_s nxt_r;

  logic [15:0] dividend;
  logic [15:0] quot;
  logic [15:0] rem;
  logic [7:0]  dec_res;
  logic        div_ovf;
  logic        ahb_go;
  logic [ddx_pkg::EV_W-1:0] ev;
  // Datapath and bus decode helpers
  logic [7:0]  divisor;
  logic [7:0]  ram_idx;
  logic        adr_ram;
  logic        adr_ok;

  ////////////////////////////////////////////////////////////////////////
  // Datapath
  always_comb begin
    divisor  = r_ff.ram[r_ff.src];
    dividend = {r_ff.ram[r_ff.dst], r_ff.ram[8'(r_ff.dst + 8'h01)]};
    div_ovf  = 1'b0;
    quot     = 16'h0000;
    rem      = 16'h0000;
    // Zero divisor is caught before the divider
    if (divisor == 8'h00) begin
      div_ovf = 1'b1;
    end else begin
      quot    = dividend / {8'h00, divisor};
      rem     = dividend % {8'h00, divisor};
      div_ovf = (quot[15:8] != 8'h00);
    end
    dec_res = r_ff.ram[r_ff.dst] - 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus address decode
  // RAM byte i sits one word per byte above the base
  always_comb begin
    ahb_go  = hsel && hready && htrans[1];
    adr_ram = (haddr >= ddx_pkg::A_RAM) && (haddr <= ddx_pkg::A_RAM_HI);
    adr_ok  = (haddr <= ddx_pkg::A_MASK) || adr_ram;
    ram_idx = 8'((haddr - ddx_pkg::A_RAM) >> 2);
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    nxt_r        = r_ff;
    ev           = '0;
    nxt_r.fstart = 1'b0;
    // Two-flop synchroniser for the wake pin
    nxt_r.irq_s1 = ext_irq;
    nxt_r.irq_s2 = r_ff.irq_s1;

    case (r_ff.st)
      ddx_pkg::ST_IDLE: begin
        if (instr_valid) begin
          nxt_r.op  = instr_op;
          nxt_r.dst = instr_dst;
          nxt_r.src = instr_src;
          if (instr_op == ddx_pkg::OP_FUZZY) begin
            nxt_r.st     = ddx_pkg::ST_FUZZ;
            nxt_r.fstart = 1'b1;
          end else if (instr_op == ddx_pkg::OP_HALT) begin
            nxt_r.st   = ddx_pkg::ST_HALT;
            ev[ddx_pkg::E_HALT] = 1'b1;
          end else if (instr_op == ddx_pkg::OP_DEC || instr_op == ddx_pkg::OP_DIV) begin
            nxt_r.st = ddx_pkg::ST_EXEC;
          end else begin
            ev[ddx_pkg::E_ILL] = 1'b1;
          end
        end
      end

      ddx_pkg::ST_EXEC: begin
        nxt_r.st = ddx_pkg::ST_IDLE;
        ev[ddx_pkg::E_DONE] = 1'b1;
        if (r_ff.op == ddx_pkg::OP_DEC) begin
          nxt_r.ram[r_ff.dst]          = dec_res;
          nxt_r.flags[ddx_pkg::F_NULL] = (dec_res == 8'h00);
          // Borrow when the old byte was zero
          nxt_r.flags[ddx_pkg::F_BRW]  = (r_ff.ram[r_ff.dst] == 8'h00);
        end else if (div_ovf) begin
          nxt_r.ram[r_ff.dst]              = ddx_pkg::ALL_ONES;
          nxt_r.ram[8'(r_ff.dst + 8'h01)]  = ddx_pkg::ALL_ONES;
          nxt_r.flags[ddx_pkg::F_OVF]      = 1'b1;
          nxt_r.flags[ddx_pkg::F_NULL]     = 1'b0;
          nxt_r.flags[ddx_pkg::F_BRW]      = 1'b0;
          ev[ddx_pkg::E_DOVF]              = 1'b1;
        end else begin
          nxt_r.ram[8'(r_ff.dst + 8'h01)]  = quot[7:0];
          nxt_r.ram[r_ff.dst]              = rem[7:0];
          nxt_r.flags[ddx_pkg::F_OVF]      = 1'b0;
          nxt_r.flags[ddx_pkg::F_NULL]     = (quot[7:0] == 8'h00);
          nxt_r.flags[ddx_pkg::F_BRW]      = (rem[7:0] == 8'h00);
        end
      end

      ddx_pkg::ST_FUZZ: begin
        // Fuzzy unit owns the stream until the closing output
        if (instr_valid) begin
          if (instr_op == ddx_pkg::OP_OUT) begin
            nxt_r.st = ddx_pkg::ST_IDLE;
            ev[ddx_pkg::E_DONE] = 1'b1;
          end else if (instr_op != ddx_pkg::OP_FZI) begin
            ev[ddx_pkg::E_ILL] = 1'b1;
          end
        end
      end

      ddx_pkg::ST_HALT: begin
        // Only the synchronised pin may wake the core
        if (r_ff.irq_s2) begin
          nxt_r.st = ddx_pkg::ST_IDLE;
          ev[ddx_pkg::E_WAKE] = 1'b1;
        end
      end

      default: nxt_r.st = ddx_pkg::ST_IDLE;
    endcase

    // Bus data phase
    nxt_r.dp_act = ahb_go;
    nxt_r.dp_wr  = hwrite;
    nxt_r.dp_idx = ram_idx;
    nxt_r.dp_ram = adr_ram;
    if (haddr == ddx_pkg::A_CTRL) begin
      nxt_r.dp_reg = 2'h0;
    end else if (haddr == ddx_pkg::A_FLAGS) begin
      nxt_r.dp_reg = 2'h1;
    end else if (haddr == ddx_pkg::A_STAT) begin
      nxt_r.dp_reg = 2'h2;
    end else begin
      nxt_r.dp_reg = 2'h3;
    end
    if (!adr_ok) begin
      nxt_r.dp_act = 1'b0;
    end

    // Read data is captured in the address phase
    if (ahb_go && !hwrite && nxt_r.dp_act) begin
      if (nxt_r.dp_ram) begin
        nxt_r.rdata = {24'h000000, r_ff.ram[ram_idx]};
      end else if (haddr == ddx_pkg::A_CTRL) begin
        nxt_r.rdata = {30'h0, r_ff.st};
      end else if (haddr == ddx_pkg::A_FLAGS) begin
        nxt_r.rdata = {29'h0, r_ff.flags};
      end else if (haddr == ddx_pkg::A_STAT) begin
        nxt_r.rdata = {27'h0, r_ff.stat};
      end else begin
        nxt_r.rdata = {27'h0, r_ff.mask};
      end
    end else if (ahb_go) begin
      nxt_r.rdata = 32'h0000_0000;
    end

    // Bus write lands last so it beats the datapath
    if (r_ff.dp_act && r_ff.dp_wr) begin
      if (r_ff.dp_ram) begin
        nxt_r.ram[r_ff.dp_idx] = hwdata[7:0];
      end else if (r_ff.dp_reg == 2'h1) begin
        nxt_r.flags = hwdata[2:0];
      end else if (r_ff.dp_reg == 2'h2) begin
        nxt_r.stat = r_ff.stat & ~hwdata[ddx_pkg::EV_W-1:0];
      end else if (r_ff.dp_reg == 2'h3) begin
        nxt_r.mask = hwdata[ddx_pkg::EV_W-1:0];
      end
    end
    // Set wins over clear
    nxt_r.stat = nxt_r.stat | ev;
    nxt_r.irq  = |(nxt_r.stat & nxt_r.mask);

    // Status outputs follow the next state
    nxt_r.rdy   = 1'b0;
    nxt_r.run   = 1'b1;
    nxt_r.halt  = 1'b0;
    nxt_r.fact  = 1'b0;
    nxt_r.hrdyo = 1'b1;
    nxt_r.hrsp  = 1'b0;
    case (nxt_r.st)
      ddx_pkg::ST_IDLE: begin
        nxt_r.rdy = 1'b1;
      end
      ddx_pkg::ST_FUZZ: begin
        nxt_r.rdy  = 1'b1;
        nxt_r.fact = 1'b1;
      end
      ddx_pkg::ST_HALT: begin
        nxt_r.run  = 1'b0;
        nxt_r.halt = 1'b1;
      end
      default: begin
        nxt_r.rdy = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_ff       <= '0;
      r_ff.flags <= ddx_pkg::FLAGS_RST;
      r_ff.st    <= ddx_pkg::ST_IDLE;
      r_ff.rdy   <= 1'b1;
      r_ff.run   <= 1'b1;
      r_ff.hrdyo <= 1'b1;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // Every output is a register bit
  assign hrdata       = r_ff.rdata;
  assign hreadyout    = r_ff.hrdyo;
  assign hresp        = r_ff.hrsp;
  assign instr_ready  = r_ff.rdy;
  assign clk_run      = r_ff.run;
  assign halt_mode    = r_ff.halt;
  assign fuzzy_active = r_ff.fact;
  assign fuzzy_start  = r_ff.fstart;
  assign irq          = r_ff.irq;

endmodule
`default_nettype wire

/* File: bench/ddx_core_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module ddx_core_properties (
  // Clock and reset
  input wire logic       hclk,
  input wire logic       hresetn,
  // Instruction stream
  input wire logic       instr_valid,
  input wire logic [2:0] instr_op,
  input wire logic       instr_ready,
  // Halt and fuzzy status
  input wire logic       ext_irq,
  input wire logic       clk_run,
  input wire logic       halt_mode,
  input wire logic       fuzzy_active,
  input wire logic       fuzzy_start
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_take(logic [2:0] o);
    instr_valid && instr_ready && !fuzzy_active && instr_op == o;
  endsequence
  sequence s_asleep;
    halt_mode && ext_irq;
  endsequence
  a_dec_busy: assert property (s_take(ddx_pkg::OP_DEC) |=> !instr_ready ##1 instr_ready)
    else $error("dec busy time wrong");
  a_div_busy: assert property (s_take(ddx_pkg::OP_DIV) |=> !instr_ready ##1 instr_ready)
    else $error("div busy time wrong");
  a_halt_enter: assert property (s_take(ddx_pkg::OP_HALT) |=> halt_mode && !clk_run)
    else $error("halt not entered");
  a_clk_gate: assert property (clk_run != halt_mode)
    else $error("clock gate wrong");
  a_halt_stall: assert property (halt_mode |-> !instr_ready)
    else $error("ready while halted");
  a_halt_hold: assert property ((!ext_irq) [*3] ##0 halt_mode |=> halt_mode)
    else $error("halt left early");
  a_halt_wake: assert property (s_asleep [*3] |-> ##[0:1] !halt_mode)
    else $error("no wake");
  a_fuzzy_go: assert property (s_take(ddx_pkg::OP_FUZZY) |=> fuzzy_start && fuzzy_active ##1 !fuzzy_start)
    else $error("fuzzy start wrong");
  a_fuzzy_hold: assert property (
    fuzzy_active && !(instr_valid && instr_ready && instr_op == ddx_pkg::OP_OUT) |=> fuzzy_active)
    else $error("fuzzy dropped early");
endmodule
bind ddx_core ddx_core_properties u_prop (
  .hclk(hclk), .hresetn(hresetn), .instr_valid(instr_valid), .instr_op(instr_op),
  .instr_ready(instr_ready), .ext_irq(ext_irq), .clk_run(clk_run), .halt_mode(halt_mode),
  .fuzzy_active(fuzzy_active), .fuzzy_start(fuzzy_start));
`default_nettype wire

/* File: bench/ddx_prog_mem.sv */
`timescale 1ns/10ps
`default_nettype none
module ddx_prog_mem (
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Bench request
  input  wire logic       req_go,
  input  wire logic [2:0] req_op,
  input  wire logic [7:0] req_dst,
  input  wire logic [7:0] req_src,
  // Instruction stream
  input  wire logic       instr_ready,
  output logic            instr_valid,
  output logic      [2:0] instr_op,
  output logic      [7:0] instr_dst,
  output logic      [7:0] instr_src
);
  // Released fields flip so stale values never look valid
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      instr_valid <= 1'b0;
      instr_op    <= 3'h0;
      instr_dst   <= 8'h00;
      instr_src   <= 8'h00;
    end else if (instr_valid) begin
      if (instr_ready) begin
        instr_valid <= 1'b0;
        instr_op    <= ~instr_op;
        instr_dst   <= ~instr_dst;
        instr_src   <= ~instr_src;
      end
    end else if (req_go) begin
      instr_valid <= 1'b1;
      instr_op    <= req_op;
      instr_dst   <= req_dst;
      instr_src   <= req_src;
    end
  end
endmodule
`default_nettype wire

/* File: bench/dec_div_fuzzy_halt_exec_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module dec_div_fuzzy_halt_exec_tb_top;
  typedef struct packed {
    logic [2:0] op;
    logic [7:0] hi, lo, sv;
    logic [2:0] pre;
    logic [7:0] eh, el;
    logic [2:0] ef;
  } ddx_row_s;
  // Op 1 decrement, op 2 divide
  ddx_row_s rows [9] = '{
    '{3'h1, 8'h32, 8'h11, 8'h01, 3'h2, 8'h31, 8'h11, 3'h2}, '{3'h1, 8'h00, 8'h11, 8'h01, 3'h2, 8'hFF, 8'h11, 3'h6},
    '{3'h1, 8'h01, 8'h11, 8'h01, 3'h2, 8'h00, 8'h11, 3'h3}, '{3'h2, 8'h05, 8'hF3, 8'h1E, 3'h7, 8'h17, 8'h32, 3'h0},
    '{3'h2, 8'h00, 8'h3C, 8'h1E, 3'h7, 8'h00, 8'h02, 3'h4}, '{3'h2, 8'h00, 8'h05, 8'h0A, 3'h7, 8'h05, 8'h00, 3'h1},
    '{3'h2, 8'h00, 8'h10, 8'h00, 3'h0, 8'hFF, 8'hFF, 3'h2}, '{3'h2, 8'h10, 8'h00, 8'h10, 3'h0, 8'hFF, 8'hFF, 3'h2},
    '{3'h2, 8'h0F, 8'hF0, 8'h10, 3'h0, 8'h00, 8'hFF, 3'h4}};
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, instr_valid, instr_ready, ext_irq;
  logic clk_run, halt_mode, fuzzy_active, fuzzy_start, irq, go;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize, instr_op, pop;
  logic [7:0] instr_dst, instr_src, pdst, psrc;
  int fail_count, cmp_count, cyc;
  ddx_core dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .instr_valid(instr_valid), .instr_op(instr_op),
    .instr_dst(instr_dst), .instr_src(instr_src), .instr_ready(instr_ready), .ext_irq(ext_irq),
    .clk_run(clk_run),
    .halt_mode(halt_mode), .fuzzy_active(fuzzy_active), .fuzzy_start(fuzzy_start), .irq(irq));
  ddx_prog_mem pm_u (.hclk(hclk), .hresetn(hresetn), .req_go(go), .req_op(pop),
    .req_dst(pdst), .req_src(psrc), .instr_dst(instr_dst), .instr_src(instr_src),
    .instr_ready(instr_ready), .instr_valid(instr_valid), .instr_op(instr_op));
  ////////////////////////////////////////////////////////////
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    {hsel, htrans, haddr, hwrite} <= {1'b1, 2'b10, a, w};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic run(input logic [2:0] o);
    @(posedge hclk);
    {pop, go} <= {o, 1'b1};
    @(posedge hclk);
    go <= 1'b0;
    do @(posedge hclk); while (instr_valid === 1'b1);
    repeat (3) @(posedge hclk);
  endtask
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      end_of_test();
    end
  end
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, ext_irq, go, pop} = '0;
    hsize = 3'h2;
    {pdst, psrc} = {8'h14, 8'h28};
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, 32'h40, 32'h0);
    chk(rd, 32'h0);
    chk({hresp, hreadyout}, 32'h1);
    chk({halt_mode, clk_run}, 32'h1);
    foreach (rows[i]) begin
      ahb(1'b1, ddx_pkg::A_RAM + 32'h50, {24'h0, rows[i].hi});
      ahb(1'b1, ddx_pkg::A_RAM + 32'h54, {24'h0, rows[i].lo});
      ahb(1'b1, ddx_pkg::A_RAM + 32'hA0, {24'h0, rows[i].sv});
      ahb(1'b1, ddx_pkg::A_FLAGS, {29'h0, rows[i].pre});
      run(rows[i].op);
      ahb(1'b0, ddx_pkg::A_RAM + 32'h50, 32'h0);
      chk(rd, {24'h0, rows[i].eh});
      ahb(1'b0, ddx_pkg::A_RAM + 32'h54, 32'h0);
      chk(rd, {24'h0, rows[i].el});
      ahb(1'b0, ddx_pkg::A_FLAGS, 32'h0);
      chk(rd, {29'h0, rows[i].ef});
    end
    {pdst, psrc} <= {8'h3C, 8'h3E};
    ahb(1'b1, ddx_pkg::A_RAM + 32'hF0, 32'h0);
    ahb(1'b1, ddx_pkg::A_RAM + 32'hF4, 32'h64);
    ahb(1'b1, ddx_pkg::A_RAM + 32'hF8, 32'h7);
    run(ddx_pkg::OP_DIV);
    ahb(1'b0, ddx_pkg::A_RAM + 32'hF0, 32'h0);
    chk(rd, 32'h2);
    ahb(1'b0, ddx_pkg::A_RAM + 32'hF4, 32'h0);
    chk(rd, 32'hE);
    ahb(1'b0, ddx_pkg::A_FLAGS, 32'h0);
    chk(rd, 32'h0);
    {pdst, psrc} <= {8'h14, 8'h28};
    ahb(1'b1, ddx_pkg::A_FLAGS, 32'h5);
    for (int i = 0; i < 2; i++) begin
      run(ddx_pkg::OP_FUZZY);
      run(ddx_pkg::OP_DEC);
      run(ddx_pkg::OP_FZI);
      chk(fuzzy_active, 32'h1);
      run(ddx_pkg::OP_OUT);
      chk(fuzzy_active, 32'h0);
    end
    ahb(1'b0, ddx_pkg::A_RAM + 32'h50, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b0, ddx_pkg::A_STAT, 32'h0);
    chk(rd, 32'h13);
    ahb(1'b1, ddx_pkg::A_MASK, 32'h4);
    run(ddx_pkg::OP_HALT);
    chk({halt_mode, clk_run, irq}, 32'h5);
    ahb(1'b1, ddx_pkg::A_STAT, 32'h1F);
    repeat (2) @(posedge hclk);
    chk(irq, 32'h0);
    ahb(1'b0, ddx_pkg::A_CTRL, 32'h0);
    chk(rd, 32'h2);
    ahb(1'b0, ddx_pkg::A_FLAGS, 32'h0);
    chk(rd, 32'h5);
    ext_irq <= 1'b1;
    for (int k = 0; k < 10 && halt_mode === 1'b1; k++) @(posedge hclk);
    ext_irq <= 1'b0;
    chk({halt_mode, clk_run}, 32'h1);
    run(ddx_pkg::OP_HALT);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({halt_mode, clk_run}, 32'h1);
    end_of_test();
  end
endmodule
`default_nettype wire
